// file: inc/appc_consts.svh
// addresses, field positions and reset values of the pad pull control registers
`ifndef APPC_CONSTS_SVH
`define APPC_CONSTS_SVH
`define APPC_ADDR_FUNC 16'hF08E
`define APPC_ADDR_SEL 16'hF08F
`define APPC_FUNC_RST 8'h00
`define APPC_SEL_RST 7'h00
`define APPC_SEL_W 7
`define APPC_B_IRQ_SEL 0
`define APPC_B_IRQ_OFF 1
`define APPC_B_RDY_SEL 2
`define APPC_B_RDY_OFF 3
`define APPC_B_DMA_OFF 4
`define APPC_B_DATA_OFF 5
`define APPC_B_VBUS_OFF 6
`define APPC_B_D7_OFF 7
`define APPC_DATA_LINE7 7
`define APPC_S_CS0 0
`define APPC_S_CS1 1
`define APPC_S_ADDR 2
`define APPC_S_DMACK 3
`define APPC_S_RD 4
`define APPC_S_WR 5
`define APPC_S_RESET 6
`endif

// file: inc/appc_pkg.sv
// types of the pad pull control block
package appc_pkg;
  typedef struct packed {
    logic irq_pu;
    logic irq_pd;
    logic rdy_pu;
    logic rdy_pd;
    logic dma_pd;
    logic [15:0] data_pd;
    logic vbus_pd;
  } appc_func_pads_t;

  typedef struct packed {
    logic [6:0] pu;
    logic [6:0] pd;
  } appc_out_pads_t;

  typedef struct packed {
    logic [7:0] func_reg;
    logic [6:0] sel_reg;
    logic [7:0] rdata;
    logic rvalid;
    appc_func_pads_t fpads;
    appc_out_pads_t opads;
  } appc_state_t;
endpackage

// file: logic/appc_pull_ctrl.sv
// pad pull-up / pull-down control registers on the controller data space
//
// Behaviour
// - functional pull register at F08E, eight bits read/write, zero at power-up.
// - functional bit 0: one pulls interrupt pin up, zero pulls it down.
// - functional bit 1: one turns both interrupt pin resistors off.
// - bits 2 and 3 do the same for the ready pin, pull-down default.
// - functional bit 4: one disconnects the DMA request pull-down.
// - functional bit 5: one disconnects pull-downs on data lines except line 7.
// - functional bit 7: one disconnects the data line 7 pull-down.
// - functional bit 6: one disconnects the bus power pin pull-down.
// - output pull select register at F08F: one pull-up, zero pull-down.
// - select bits 0..6 map to output pins in order; bit 7 reads zero.
// - writing one to hard-reset control clears select bit 6.
// - select register resets to zero: all output pins pulled down.
// - a power-down bit of one turns both resistors of that pin off.
`timescale 1ns/10ps
`include "appc_consts.svh"

module appc_pull_ctrl (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // controller data space access
  input wire logic [15:0] xaddr_i,
  input wire logic xwr_i,
  input wire logic xrd_i,
  input wire logic [7:0] xwdata_i,
  output logic [7:0] xrdata_o,
  output logic xrvalid_o,
  // companion state from outside
  input wire logic [6:0] ata_output_pull_powerdown_i,
  input wire logic ata_hard_reset_set_i,
  // pad controls
  output appc_pkg::appc_func_pads_t func_pads_o,
  output appc_pkg::appc_out_pads_t out_pads_o
);

  appc_pkg::appc_state_t state_reg;
  appc_pkg::appc_state_t state_next;

  logic hit_func;
  logic hit_sel;

  // two bits {pull-up, pull-down} from select and off
  function automatic logic [1:0] pull_pair(input logic sel, input logic off);
    pull_pair = {sel & ~off, ~sel & ~off};
  endfunction

  assign hit_func = (xaddr_i == `APPC_ADDR_FUNC);
  assign hit_sel = (xaddr_i == `APPC_ADDR_SEL);

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    // writes
    if (xwr_i && hit_func) begin
      state_next.func_reg = xwdata_i;
    end
    if (xwr_i && hit_sel) begin
      state_next.sel_reg = xwdata_i[6:0];
    end
    // hardware clear beats a same-cycle software write of the bit
    if (ata_hard_reset_set_i) begin
      state_next.sel_reg[`APPC_S_RESET] = 1'b0;
    end
    // reads return the stored value; unmapped reads return zero
    if (xrd_i) begin
      state_next.rvalid = 1'b1;
      if (hit_func) begin
        state_next.rdata = state_reg.func_reg;
      end else if (hit_sel) begin
        state_next.rdata = {1'b0, state_reg.sel_reg};
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    // pads follow the registers one cycle late so every pad control is a flop
    {state_next.fpads.irq_pu, state_next.fpads.irq_pd} =
      pull_pair(state_reg.func_reg[`APPC_B_IRQ_SEL], state_reg.func_reg[`APPC_B_IRQ_OFF]);
    {state_next.fpads.rdy_pu, state_next.fpads.rdy_pd} =
      pull_pair(state_reg.func_reg[`APPC_B_RDY_SEL], state_reg.func_reg[`APPC_B_RDY_OFF]);
    state_next.fpads.dma_pd = ~state_reg.func_reg[`APPC_B_DMA_OFF];
    state_next.fpads.data_pd = {16{~state_reg.func_reg[`APPC_B_DATA_OFF]}};
    state_next.fpads.data_pd[`APPC_DATA_LINE7] = ~state_reg.func_reg[`APPC_B_D7_OFF];
    state_next.fpads.vbus_pd = ~state_reg.func_reg[`APPC_B_VBUS_OFF];
    for (int i = 0; i < `APPC_SEL_W; i++) begin
      {state_next.opads.pu[i], state_next.opads.pd[i]} =
        pull_pair(state_reg.sel_reg[i], ata_output_pull_powerdown_i[i]);
    end
  end

  // reset leaves every pull-down on: output buffers are off at power-up
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.func_reg <= `APPC_FUNC_RST;
      state_reg.sel_reg <= `APPC_SEL_RST;
      state_reg.fpads.irq_pd <= 1'b1;
      state_reg.fpads.rdy_pd <= 1'b1;
      state_reg.fpads.dma_pd <= 1'b1;
      state_reg.fpads.data_pd <= 16'hFFFF;
      state_reg.fpads.vbus_pd <= 1'b1;
      state_reg.opads.pd <= 7'h7F;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign xrdata_o = state_reg.rdata;
  assign xrvalid_o = state_reg.rvalid;
  assign func_pads_o = state_reg.fpads;
  assign out_pads_o = state_reg.opads;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // register bus checks
  // the controller model leaves one idle cycle between accesses, so the read comes two cycles later
  chk_func_write_read: assert property (
    ce_i && xwr_i && hit_func && !xrd_i ##1 !(ce_i && xwr_i && hit_func) ##1 ce_i && xrd_i && hit_func && !xwr_i
    |=> xrvalid_o && xrdata_o == $past(xwdata_i, 3))
    else $error("functional register readback differs from write");

  chk_irq_pair: assert property (
    ce_i |=> func_pads_o.irq_pu == ($past(state_reg.func_reg[0]) & ~$past(state_reg.func_reg[1]))
      && func_pads_o.irq_pd == (~$past(state_reg.func_reg[0]) & ~$past(state_reg.func_reg[1])))
    else $error("interrupt pin pull enables wrong");

  chk_ready_pair: assert property (
    ce_i && state_reg.func_reg[3] |=> !func_pads_o.rdy_pu && !func_pads_o.rdy_pd)
    else $error("ready pin pull not off");

  chk_ready_default: assert property (
    ce_i && state_reg.func_reg[3:2] == 2'b00 |=> func_pads_o.rdy_pd && !func_pads_o.rdy_pu)
    else $error("ready pin pull-down not on");

  chk_dma_vbus_pd: assert property (
    ce_i |=> func_pads_o.dma_pd == !$past(state_reg.func_reg[4])
      && func_pads_o.vbus_pd == !$past(state_reg.func_reg[6]))
    else $error("dma request or bus power pull-down wrong");

  chk_data_lines: assert property (
    ce_i && state_reg.func_reg[7:5] == 3'b001 |=> func_pads_o.data_pd == 16'h0080)
    else $error("data line pull-downs wrong");

  // a frozen valid must not be blamed on a later address, so the read itself is looked at
  chk_sel_mask: assert property (
    ce_i && xrd_i && hit_sel |=> xrvalid_o && !xrdata_o[7])
    else $error("reserved select bit reads one");

  chk_hard_reset_clr: assert property (
    ce_i && ata_hard_reset_set_i |=> !state_reg.sel_reg[6])
    else $error("reset output select bit survives hard reset");

  chk_out_pads: assert property (
    ce_i |=> out_pads_o.pu == ($past(state_reg.sel_reg) & ~$past(ata_output_pull_powerdown_i))
      && out_pads_o.pd == (~$past(state_reg.sel_reg) & ~$past(ata_output_pull_powerdown_i)))
    else $error("output pin pull enables wrong");

  chk_sel_write: assert property (
    ce_i && xwr_i && hit_sel && !ata_hard_reset_set_i |=> state_reg.sel_reg == $past(xwdata_i[6:0]))
    else $error("select register write lost");

  chk_read_pulse: assert property (
    ce_i && xrd_i
    |=> xrvalid_o)
    else $error("read gave no valid pulse");

  chk_valid_single: assert property (
    ce_i && !xrd_i
    |=> !xrvalid_o)
    else $error("valid pulse without a read");

  chk_unmapped_read: assert property (
    ce_i && xrd_i && !hit_func && !hit_sel
    |=> xrdata_o == 8'h00)
    else $error("unmapped read returned data");

  chk_func_readback: assert property (
    ce_i && xrd_i && hit_func
    |=> xrdata_o == $past(state_reg.func_reg))
    else $error("functional register read wrong");

  chk_sel_readback: assert property (
    ce_i && xrd_i && hit_sel
    |=> xrdata_o == {1'b0, $past(state_reg.sel_reg)})
    else $error("select register read wrong");

  chk_rdata_hold: assert property (
    ce_i && !xrd_i
    |=> $stable(xrdata_o))
    else $error("read data moved without a read");

  chk_func_write: assert property (
    ce_i && xwr_i && hit_func
    |=> state_reg.func_reg == $past(xwdata_i))
    else $error("functional register write lost");

  chk_func_keep: assert property (
    ce_i && !(xwr_i && hit_func)
    |=> $stable(state_reg.func_reg))
    else $error("functional register changed without a write");

  chk_sel_keep: assert property (
    ce_i && !(xwr_i && hit_sel) && !ata_hard_reset_set_i
    |=> $stable(state_reg.sel_reg))
    else $error("select register changed without a write");

  // a same-cycle write keeps its other bits; only the reset output bit is forced low
  chk_sel_clear_wins: assert property (
    ce_i && xwr_i && hit_sel && ata_hard_reset_set_i
    |=> state_reg.sel_reg == ($past(xwdata_i[6:0]) & 7'h3F))
    else $error("hard reset clear lost against write");

  // clock enable low must freeze every flop, pads included
  chk_freeze_regs: assert property (
    !ce_i
    |=> $stable(state_reg))
    else $error("state moved while clock enable low");

  chk_freeze_pads: assert property (
    !ce_i
    |=> $stable(func_pads_o) && $stable(out_pads_o))
    else $error("pads moved while clock enable low");

  // reset values as seen at the first edge after release
  chk_reset_values: assert property (
    $fell(rst_i)
    |-> state_reg.func_reg == 8'h00 && state_reg.sel_reg == 7'h00 && !xrvalid_o && xrdata_o == 8'h00
      && out_pads_o.pd == 7'h7F && out_pads_o.pu == 7'h00 && func_pads_o.data_pd == 16'hFFFF)
    else $error("reset values wrong");

  // pad checks
  chk_irq_off: assert property (
    ce_i && state_reg.func_reg[1]
    |=> !func_pads_o.irq_pu && !func_pads_o.irq_pd)
    else $error("interrupt pin pull not off");

  chk_ready_up: assert property (
    ce_i && state_reg.func_reg[3:2] == 2'b01
    |=> func_pads_o.rdy_pu && !func_pads_o.rdy_pd)
    else $error("ready pin pull-up not on");

  chk_data_off: assert property (
    ce_i && state_reg.func_reg[5]
    |=> func_pads_o.data_pd[15:8] == 8'h00 && func_pads_o.data_pd[6:0] == 7'h00)
    else $error("data line pull-downs not off");

  chk_data_on: assert property (
    ce_i && !state_reg.func_reg[5]
    |=> func_pads_o.data_pd[15:8] == 8'hFF && func_pads_o.data_pd[6:0] == 7'h7F)
    else $error("data line pull-downs not on");

  chk_line7_pd: assert property (
    ce_i
    |=> func_pads_o.data_pd[7] == !$past(state_reg.func_reg[7]))
    else $error("data line 7 pull-down wrong");

  chk_hard_pad6: assert property (
    ce_i && !state_reg.sel_reg[6]
    |=> !out_pads_o.pu[6])
    else $error("reset output pull-up survives hard reset");

  chk_out_powerdown: assert property (
    ce_i && ata_output_pull_powerdown_i == 7'h7F
    |=> out_pads_o.pu == 7'h00 && out_pads_o.pd == 7'h00)
    else $error("powered down output pulls still on");

  // a pin must never see both resistors at once
  chk_out_exclusive: assert property (
    (out_pads_o.pu & out_pads_o.pd) == 7'h00)
    else $error("output pin has both pulls on");

  chk_func_exclusive: assert property (
    !(func_pads_o.irq_pu && func_pads_o.irq_pd) && !(func_pads_o.rdy_pu && func_pads_o.rdy_pd))
    else $error("functional pin has both pulls on");

endmodule

// file: sim/appc_mcu_model.sv
// controller model that makes single-byte data-space accesses
`timescale 1ns/10ps
module appc_mcu_model (
  // clock
  input wire logic clk_sys_i,
  // data space
  output logic [15:0] xaddr_o,
  output logic xwr_o,
  output logic xrd_o,
  output logic [7:0] xwdata_o
);
  initial begin
    xaddr_o = 16'h0000;
    xwr_o = 1'b0;
    xrd_o = 1'b0;
    xwdata_o = 8'h00;
  end
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    xaddr_o = a;
    xwdata_o = d;
    xwr_o = w;
    xrd_o = !w;
    @(negedge clk_sys_i);
    xwr_o = 1'b0;
    xrd_o = 1'b0;
    // released data is inverted so a stale byte never passes for a fresh one
    xwdata_o = ~d;
  endtask
endmodule

// file: sim/appc_pull_ctrl_tb_top.sv
// self-checking bench of the pad pull control registers
`timescale 1ns/10ps
`include "appc_consts.svh"
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected %0t mismatch got %h want %h", $time, a, e); end end
module appc_pull_ctrl_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic hard_i = 1'b0;
  logic [6:0] pd_i = 7'h00;
  logic [15:0] xaddr_i;
  logic xwr_i;
  logic xrd_i;
  logic [7:0] xwdata_i;
  logic [7:0] xrdata_o;
  logic xrvalid_o;
  logic [7:0] r = 8'h3C;
  logic [7:0] f;
  logic [7:0] s;
  appc_pkg::appc_func_pads_t func_pads_o;
  appc_pkg::appc_out_pads_t out_pads_o;
  logic [7:0] q[$];
  int checks = 0;
  int n_mismatch = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  appc_mcu_model i_mcu (.clk_sys_i(clk_sys_i), .xaddr_o(xaddr_i), .xwr_o(xwr_i), .xrd_o(xrd_i), .xwdata_o(xwdata_i));
  appc_pull_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .xaddr_i(xaddr_i), .xwr_i(xwr_i),
    .xrd_i(xrd_i), .xwdata_i(xwdata_i), .xrdata_o(xrdata_o), .xrvalid_o(xrvalid_o),
    .ata_output_pull_powerdown_i(pd_i), .ata_hard_reset_set_i(hard_i), .func_pads_o(func_pads_o),
    .out_pads_o(out_pads_o));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic appc_pkg::appc_func_pads_t fexp(input logic [7:0] v);
    return {v[0] & !v[1], !v[0] & !v[1], v[2] & !v[3], !v[2] & !v[3], !v[4], {8{!v[5]}}, !v[7], {7{!v[5]}}, !v[6]};
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_mcu.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    i_mcu.acc(1'b0, a, 8'h00);
  endtask
  task automatic pads(input logic [7:0] v, input logic [6:0] sel);
    repeat (3) @(negedge clk_sys_i);
    `CMP(func_pads_o, fexp(v))
    `CMP(out_pads_o, {sel & ~pd_i, ~sel & ~pd_i})
  endtask
  task automatic pulse;
    hard_i = 1'b1;
    @(negedge clk_sys_i);
    hard_i = 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data is matched against the oldest note when the valid pulse shows
  always @(negedge clk_sys_i) begin
    if (xrvalid_o === 1'b1) `CMP(xrdata_o, q.pop_front())
  end
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    pads(8'h00, 7'h00);
    rd(`APPC_ADDR_FUNC, 8'h00);
    rd(`APPC_ADDR_SEL, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      f = r;
      r = lfsr(r);
      s = r;
      r = lfsr(r);
      pd_i = r[6:0];
      wr(`APPC_ADDR_SEL, s);
      wr(`APPC_ADDR_FUNC, f);
      rd(`APPC_ADDR_FUNC, f);
      rd(`APPC_ADDR_SEL, {1'b0, s[6:0]});
      pads(f, s[6:0]);
    end
    $display("test random done");
    // ready pull-up on, bus power pull-down off, output pulls powered down
    wr(`APPC_ADDR_FUNC, 8'h44);
    pd_i = 7'h7F;
    ce_i = 1'b0;
    wr(`APPC_ADDR_FUNC, 8'hFF);
    ce_i = 1'b1;
    wr(16'hF091, 8'hFF);
    rd(16'hF090, 8'h00);
    rd(`APPC_ADDR_FUNC, 8'h44);
    pads(8'h44, s[6:0]);
    $display("test ignore done");
    pd_i = 7'h00;
    wr(`APPC_ADDR_SEL, 8'h7F);
    pulse();
    rd(`APPC_ADDR_SEL, 8'h3F);
    fork
      wr(`APPC_ADDR_SEL, 8'h7F);
      begin
        @(negedge clk_sys_i);
        pulse();
      end
    join
    rd(`APPC_ADDR_SEL, 8'h3F);
    pads(8'h44, 7'h3F);
    $display("test hard reset done");
    rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    pads(8'h00, 7'h00);
    rd(`APPC_ADDR_FUNC, 8'h00);
    rd(`APPC_ADDR_SEL, 8'h00);
    $display("test mid reset done");
    results();
  end
  initial begin
    #(2000 * 50);
    n_mismatch++;
    results();
  end
endmodule
